// ### scan_line_timing_generator_tb.sv
// Self-checking bench for the scan-line timing generator
`timescale 1ns/1ps
module scan_line_timing_generator_tb;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic fire = 1'b0;
	logic [7:0] half_per = 8'h0A;
	logic [7:0] rise_age;
	logic clk300_in, once_around_in, cnt_clear_r, mirror_phase_r;
	logic level_clamp_space_r, level_clamp_ground_r, sub_sync1_mark, sub_sync2_mark;
	logic post_sync_mark, step_gate_r, blank_r;
	logic [15:0] line_count_r;
	logic [9:0] dec_pulse_r;
	logic [2:0] step_level_r;
	int n_errors = 0;
	int tests_run = 0;
	// Decoder positions worked out from the listed counter ones
	logic [15:0] exp_mask [10] = '{16'h04E0, 16'h09C4, 16'h1968, 16'h36A8, 16'h4480,
		16'h4F80, 16'h57E4, 16'h629C, 16'h9856, 16'hAC54};

	always #5 sys_clk = ~sys_clk;

	scltg_partner far (.sys_clk, .half_per, .fire, .clk300(clk300_in),
		.pickup(once_around_in), .rise_age);

	scltg_top dut (.sys_clk, .rst, .clk_en, .clk300_in, .once_around_in, .cnt_clear_r,
		.mirror_phase_r, .level_clamp_space_r, .level_clamp_ground_r, .line_count_r,
		.dec_pulse_r, .sub_sync1_mark, .sub_sync2_mark, .post_sync_mark, .step_gate_r,
		.step_level_r, .blank_r);

	task automatic chk_bit(string what, logic exp, logic got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chk_word(string what, logic [15:0] exp, logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic complete_run();
		if (n_errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Pickup pulse, then a bounded wait for the line to start
	task automatic sync_line(int lim);
		int k;
		fire <= 1'b1;
		repeat (2) @(negedge sys_clk);
		fire <= 1'b0;
		for (k = 0; k < lim && cnt_clear_r !== 1'b1; k++) @(negedge sys_clk);
		chk_bit("cnt_clear", 1'b1, cnt_clear_r);
	endtask

	// Pickup at several phases of a slow clock; each restarts the line
	task automatic sync_phases();
		int p;
		for (p = 0; p < 4; p++) begin
			repeat (30 + 3 * p) @(negedge sys_clk);
			sync_line(26);
			chk_word("clock_age", 16'h0002, {8'h00, rise_age});
			chk_word("line_count", 16'h0000, line_count_r);
			chk_bit("mirror", 1'b1, mirror_phase_r);
			chk_bit("space", 1'b1, level_clamp_space_r);
			chk_bit("ground", 1'b1, level_clamp_ground_r);
		end
	endtask

	// Enable low must hold the counter still
	task automatic freeze();
		logic [15:0] held;
		held = line_count_r;
		clk_en = 1'b0;
		repeat (40) @(negedge sys_clk);
		chk_word("frozen", held, line_count_r);
		clk_en = 1'b1;
	endtask

	// One whole line at the fastest clock the sync logic can follow
	task automatic run_line();
		logic [15:0] c;
		logic [15:0] pc;
		logic [9:0] pd;
		logic g;
		int fires [10];
		int i;
		int n;
		sync_line(8);
		pc = 16'h0000;
		pd = 10'h000;
		for (i = 0; i < 10; i++) fires[i] = 0;
		for (n = 0; n < 95000 && pc != 16'hAC62; n++) begin
			@(negedge sys_clk);
			c = line_count_r;
			chk_bit("cnt_clear", c == 16'h0000, cnt_clear_r);
			chk_bit("mirror", c == 16'h0000, mirror_phase_r);
			chk_bit("space", c < 16'h012C, level_clamp_space_r);
			chk_bit("ground", c < 16'h0096, level_clamp_ground_r);
			for (i = 0; i < 10; i++) begin
				if (dec_pulse_r[i] === 1'b1) chk_word("dec_at", exp_mask[i] + 16'h0001, c);
				if (dec_pulse_r[i] === 1'b1 && pd[i] !== 1'b1) fires[i]++;
			end
			pd = dec_pulse_r;
			if (c != pc) begin
				chk_word("count_step", pc + 16'h0001, c);
				// Mid-step samples stay clear of one-cycle register lag
				g = c > 16'h4480 && c < 16'h4C80;
				if (c[7:0] == 8'h40) begin
					chk_bit("step_gate", g, step_gate_r);
					chk_word("step_level", g ? (c - 16'h4540) >> 8 : 16'h0000, {13'h0000, step_level_r});
					chk_bit("blank", g, blank_r);
				end
				if (c inside {16'h1973, 16'h197B, 16'h1983}) chk_bit("sub1", c == 16'h197B, sub_sync1_mark);
				if (c inside {16'h36B3, 16'h36BB, 16'h36C3}) chk_bit("sub2", c == 16'h36BB, sub_sync2_mark);
				if (c inside {16'h5040, 16'h50C0, 16'h5140}) chk_bit("post", c == 16'h50C0, post_sync_mark);
				pc = c;
			end
		end
		chk_word("line_end", 16'hAC62, pc);
		for (i = 0; i < 10; i++) chk_word("fires", 16'h0001, 16'(fires[i]));
	endtask

	// Main sequence
	initial begin
		repeat (5) @(negedge sys_clk);
		rst = 1'b0;
		chk_word("count_rst", 16'h0000, line_count_r);
		chk_word("dec_rst", 16'h0000, {6'h00, dec_pulse_r});
		sync_phases();
		freeze();
		half_per <= 8'h01;
		repeat (4) @(negedge sys_clk);
		run_line();
		complete_run();
	end

	// Cut a hang short well after the longest line should have ended
	initial begin
		#990_000;
		n_errors++;
		complete_run();
	end
endmodule // scan_line_timing_generator_tb

// ### scltg_marker.sv
// Half-cycle sync marker shaper driven by a counter-derived gating clock
`timescale 1ns/1ps
module scltg_marker
	import scltg_pkg::*;
(
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Trigger and gating clock level
	input wire logic trig,
	input wire logic gclk,
	// Shaped marker
	output logic pulse_r
);

	typedef enum logic [1:0] {SCLTG_MK_IDLE, SCLTG_MK_WAIT_LOW, SCLTG_MK_WAIT_HIGH,
		SCLTG_MK_HIGH} scltg_mk_t;

	scltg_mk_t state_r;
	scltg_mk_t state_nxt;
	logic pulse_nxt;

	// Waiting for a low half first gives a full-width high half every time
	always_comb begin
		state_nxt = state_r;
		pulse_nxt = pulse_r;
		case (state_r)
			SCLTG_MK_IDLE: begin
				if (trig) begin
					state_nxt = SCLTG_MK_WAIT_LOW; // R19
				end
			end
			SCLTG_MK_WAIT_LOW: begin
				if (!gclk) begin
					state_nxt = SCLTG_MK_WAIT_HIGH;
				end
			end
			SCLTG_MK_WAIT_HIGH: begin
				if (gclk) begin
					state_nxt = SCLTG_MK_HIGH; // R19
					pulse_nxt = 1'b1;
				end
			end
			SCLTG_MK_HIGH: begin
				if (!gclk) begin
					state_nxt = SCLTG_MK_IDLE; // R19
					pulse_nxt = 1'b0;
				end
			end
			default: begin
				state_nxt = SCLTG_MK_IDLE;
				pulse_nxt = 1'b0;
			end
		endcase
	end

	// State registers, frozen while the enable is low
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r <= SCLTG_MK_IDLE;
			pulse_r <= 1'b0;
		end else if (clk_en) begin
			state_r <= state_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	// Marker ends on the falling gating clock
	property p_mk_fall;
		@(posedge sys_clk) disable iff (rst)
		(pulse_r && clk_en && !gclk) |=> !pulse_r;
	endproperty
	a_mk_fall: assert property (p_mk_fall) else $error("marker outlived its half cycle"); // R19

	// Marker starts only on a high gating clock
	property p_mk_rise;
		@(posedge sys_clk) disable iff (rst)
		$rose(pulse_r) |-> $past(gclk);
	endproperty
	a_mk_rise: assert property (p_mk_rise) else $error("marker rose on low gating clock"); // R19

endmodule // scltg_marker

// ### scltg_partner.sv
// Behavioural far side: spacecraft 300 kHz clock and encoder pickup
`timescale 1ns/1ps
module scltg_partner (
	// Bench clock and controls
	input wire logic sys_clk,
	input wire logic [7:0] half_per,
	input wire logic fire,
	// Far-side outputs
	output logic clk300,
	output logic pickup,
	// Edges since the clock last rose
	output logic [7:0] rise_age
);
	logic [7:0] ph = 8'h00;
	logic prev = 1'b0;

	initial begin
		clk300 = 1'b0;
		pickup = 1'b0;
		rise_age = 8'h00;
	end

	// Levels move off the sampling edge so the design sees clean values
	always @(negedge sys_clk) begin
		pickup <= fire;
		if (ph + 8'h01 >= half_per) begin
			ph <= 8'h00;
			clk300 <= ~clk300;
		end else begin
			ph <= ph + 8'h01;
		end
	end

	// Age counter saturates; only the first few edges matter
	always @(posedge sys_clk) begin
		prev <= clk300;
		if (clk300 && !prev) begin
			rise_age <= 8'h01;
		end else if (rise_age != 8'hFF) begin
			rise_age <= rise_age + 8'h01;
		end
	end
endmodule // scltg_partner

// ### scltg_pkg.sv
// Constants shared by the scan-line timing generator files
package scltg_pkg;

	// Primary counter width and decoder count
	localparam int SCLTG_CNT_W = 16;
	localparam int SCLTG_NUM_DEC = 10;

	// Decoder slots, index into the mask table
	localparam int SCLTG_DEC_READ_WARM = 0;
	localparam int SCLTG_DEC_READ_COLD = 1;
	localparam int SCLTG_DEC_SUB1 = 2;
	localparam int SCLTG_DEC_SUB2 = 3;
	localparam int SCLTG_DEC_STEP = 4;
	localparam int SCLTG_DEC_POST = 5;
	localparam int SCLTG_DEC_INDEX = 6;
	localparam int SCLTG_DEC_SAMP_WARM = 7;
	localparam int SCLTG_DEC_SAMP_COLD = 8;
	localparam int SCLTG_DEC_PRECURSOR = 9;

	// Counter ones per decoder, counter bit n sits at index n-1
	localparam logic [15:0] SCLTG_DEC_MASK [0:9] = '{
		16'h04E0, // R8
		16'h09C4, // R9
		16'h1968, // R10
		16'h36A8, // R11
		16'h4480, // R12
		16'h4F80, // R13
		16'h57E4, // R14
		16'h629C,
		16'h9856, // R15
		16'hAC54  // R16
	};

	// Gating clocks taken from primary counter bits (1.17 kHz and 18.75 kHz)
	localparam int SCLTG_CAL_CLK_BIT = 7;
	localparam int SCLTG_SUB_CLK_BIT = 3;
	// Low counter bits just before the 1.17 kHz bit rises
	localparam logic [7:0] SCLTG_CAL_EDGE_PAT = 8'h7F;

	// Level-clamp gate windows in 300 kHz periods after line sync
	localparam logic [15:0] SCLTG_SPACE_GATE_TICKS = 16'h012C;
	localparam logic [15:0] SCLTG_GROUND_GATE_TICKS = 16'h0096;

	// Step calibration counter
	localparam int SCLTG_STEP_W = 3;
	localparam logic [2:0] SCLTG_STEP_FULL = 3'h7;

	// Reset values
	localparam logic [15:0] SCLTG_CNT_RST = 16'h0000;
	localparam logic [2:0] SCLTG_STEP_RST = 3'h0;

endpackage

// ### scltg_top.sv
// Scan-line timing generator: sync, primary counter, decoders, step calibration
//
// Contract
// R1: Line events timed from external 300 kHz
// R2: Once-around pulse waits for next 300 kHz
// R3: Space and ground gates from sync pulse
// R4: Sync pulse clears the primary counter
// R5: Sync pulse gives mirror phasing reference
// R6: Other functions from 16-bit 300 kHz counter
// R7: Ten decoders, listed counter bits all ones
// R8: Read warm target at bits 11,8-6
// R9: Read cold target at bits 12,9-7,3
// R10: First sub-sync at bits 13,12,9,7,6,4
// R11: Second sub-sync at bits 14,13,11,10,8,6,4
// R12: Step calibration start at bits 15,11,8
// R13: Post-sync at bits 15,12-8
// R14: Half-revolution index at bits 15,13,11-6,3
// R15: Cold sample at bits 16,13,12,7,5,3,2
// R16: Precursor at bits 16,14,12,11,7,5,3
// R17: Blank radiance while inserted signals present
// R18: Gated 1.17 kHz drives 3-bit step counter
// R19: Markers shaped to one gating half-cycle
// R20: Decoder pulse lasts one 300 kHz period
`timescale 1ns/1ps
module scltg_top
	import scltg_pkg::*;
(
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Spacecraft clock and encoder
	input wire logic clk300_in,
	input wire logic once_around_in,
	// Pulses taken straight from the synchronized pickup
	output logic cnt_clear_r,
	output logic mirror_phase_r,
	output logic level_clamp_space_r,
	output logic level_clamp_ground_r,
	// Primary counter
	output logic [SCLTG_CNT_W-1:0] line_count_r,
	// Decoder pulses, one per slot
	output logic [SCLTG_NUM_DEC-1:0] dec_pulse_r,
	// Shaped sync markers
	output logic sub_sync1_mark,
	output logic sub_sync2_mark,
	output logic post_sync_mark,
	// Step calibration
	output logic step_gate_r,
	output logic [SCLTG_STEP_W-1:0] step_level_r,
	// Radiance blanking
	output logic blank_r
);

	// 300 kHz edge detect and pending once-around
	logic clk300_r;
	logic clk300_nxt;
	logic clk300_d_r;
	logic clk300_d_nxt;
	logic pend_r;
	logic pend_nxt;
	logic once_d_r;
	logic once_d_nxt;
	logic pickup;
	logic tick;
	logic sync;

	// Line state
	logic [SCLTG_CNT_W-1:0] cnt_nxt;
	logic [SCLTG_NUM_DEC-1:0] fired_r;
	logic [SCLTG_NUM_DEC-1:0] fired_nxt;
	logic [SCLTG_NUM_DEC-1:0] dec_nxt;
	logic [SCLTG_NUM_DEC-1:0] hit;
	logic [SCLTG_NUM_DEC-1:0] dec_trig;
	logic cnt_clear_nxt;
	logic mirror_phase_nxt;
	logic space_nxt;
	logic ground_nxt;
	logic in_line_r;
	logic in_line_nxt;

	// Step calibration state
	logic cal_tick;
	logic step_gate_nxt;
	logic [SCLTG_STEP_W-1:0] step_level_nxt;
	logic blank_nxt;

	// Edge of the 300 kHz clock, taken as one sys_clk strobe
	assign tick = clk_en & clk300_r & ~clk300_d_r; // R1
	// Only the leading edge counts, so a wide pickup starts one line only
	assign pickup = clk_en & once_around_in & ~once_d_r; // R2
	// A pending or arriving once-around lands on the next 300 kHz edge
	assign sync = tick & (pend_r | pickup); // R2
	// Rising edge of the 1.17 kHz counter bit
	assign cal_tick = tick & ~sync & (line_count_r[7:0] == SCLTG_CAL_EDGE_PAT); // R18

	// Decoders look only at the listed ones, as a wired AND would
	genvar gi;
	generate
		for (gi = 0; gi < SCLTG_NUM_DEC; gi = gi + 1) begin : g_dec
			assign hit[gi] = ((line_count_r & SCLTG_DEC_MASK[gi]) == SCLTG_DEC_MASK[gi]); // R7
			assign dec_trig[gi] = tick & ~sync & in_line_r & hit[gi] & ~fired_r[gi]; // R20

			// Decoder pulse holds one whole 300 kHz period
			property p_dec_fire;
				@(posedge sys_clk) disable iff (rst)
				dec_trig[gi] |=> dec_pulse_r[gi];
			endproperty
			a_dec_fire: assert property (p_dec_fire) else $error("decoder missed its pattern"); // R7

			property p_dec_hold;
				@(posedge sys_clk) disable iff (rst)
				(dec_pulse_r[gi] && !tick) |=> dec_pulse_r[gi];
			endproperty
			a_dec_hold: assert property (p_dec_hold) else $error("decoder pulse cut short"); // R20

			property p_dec_once;
				@(posedge sys_clk) disable iff (rst)
				(fired_r[gi] && !sync) |=> !$rose(dec_pulse_r[gi]);
			endproperty
			a_dec_once: assert property (p_dec_once) else $error("decoder fired twice in a line"); // R20
		end
	endgenerate

	// Sync, counter and decoder next values
	always_comb begin
		clk300_nxt = clk300_in;
		clk300_d_nxt = clk300_r;
		once_d_nxt = once_around_in;
		pend_nxt = pend_r;
		cnt_nxt = line_count_r;
		fired_nxt = fired_r;
		dec_nxt = dec_pulse_r;
		cnt_clear_nxt = cnt_clear_r;
		mirror_phase_nxt = mirror_phase_r;
		space_nxt = level_clamp_space_r;
		ground_nxt = level_clamp_ground_r;
		in_line_nxt = in_line_r;
		if (pickup) begin
			pend_nxt = 1'b1; // R2
		end
		if (sync) begin
			pend_nxt = 1'b0;
			in_line_nxt = 1'b1; // R1
			cnt_nxt = SCLTG_CNT_RST; // R4
			fired_nxt = '0;
			dec_nxt = '0;
			cnt_clear_nxt = 1'b1; // R4
			mirror_phase_nxt = 1'b1; // R5
			space_nxt = 1'b1; // R3
			ground_nxt = 1'b1; // R3
		end else if (tick) begin
			// Free count wraps if the encoder stops; fired flags stop repeats
			cnt_nxt = line_count_r + 16'h0001; // R6
			cnt_clear_nxt = 1'b0;
			mirror_phase_nxt = 1'b0;
			fired_nxt = fired_r | dec_trig;
			dec_nxt = dec_trig; // R20
			if (line_count_r >= SCLTG_SPACE_GATE_TICKS - 16'h0001) begin
				space_nxt = 1'b0; // R3
			end
			if (line_count_r >= SCLTG_GROUND_GATE_TICKS - 16'h0001) begin
				ground_nxt = 1'b0; // R3
			end
		end
	end

	// Sync and counter registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			clk300_r <= 1'b0;
			clk300_d_r <= 1'b0;
			once_d_r <= 1'b0;
			pend_r <= 1'b0;
			line_count_r <= SCLTG_CNT_RST;
			fired_r <= '0;
			dec_pulse_r <= '0;
			cnt_clear_r <= 1'b0;
			mirror_phase_r <= 1'b0;
			level_clamp_space_r <= 1'b0;
			level_clamp_ground_r <= 1'b0;
			in_line_r <= 1'b0;
		end else if (clk_en) begin
			clk300_r <= clk300_nxt;
			clk300_d_r <= clk300_d_nxt;
			once_d_r <= once_d_nxt;
			pend_r <= pend_nxt;
			line_count_r <= cnt_nxt;
			fired_r <= fired_nxt;
			dec_pulse_r <= dec_nxt;
			cnt_clear_r <= cnt_clear_nxt;
			mirror_phase_r <= mirror_phase_nxt;
			level_clamp_space_r <= space_nxt;
			level_clamp_ground_r <= ground_nxt;
			in_line_r <= in_line_nxt;
		end
	end

	// Step calibration and blanking next values
	always_comb begin
		step_gate_nxt = step_gate_r;
		step_level_nxt = step_level_r;
		if (step_gate_r && cal_tick) begin
			step_level_nxt = step_level_r + 3'h1; // R18
			if (step_level_r == SCLTG_STEP_FULL) begin
				step_gate_nxt = 1'b0; // R18
			end
		end
		// Start wins over the end of an earlier sequence
		if (dec_trig[SCLTG_DEC_STEP]) begin
			step_gate_nxt = 1'b1; // R18
			step_level_nxt = SCLTG_STEP_RST;
		end
		// The gate also steers the mux, so the wrap back to step 0 never shows
		blank_nxt = step_gate_r | cnt_clear_r | sub_sync1_mark | sub_sync2_mark
			| post_sync_mark | dec_pulse_r[SCLTG_DEC_READ_WARM]
			| dec_pulse_r[SCLTG_DEC_READ_COLD]; // R17
	end

	// Step calibration and blanking registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			step_gate_r <= 1'b0;
			step_level_r <= SCLTG_STEP_RST;
			blank_r <= 1'b0;
		end else if (clk_en) begin
			step_gate_r <= step_gate_nxt;
			step_level_r <= step_level_nxt;
			blank_r <= blank_nxt;
		end
	end

	// Sub-sync markers on the 18.75 kHz bit, post-sync on the 1.17 kHz bit
	scltg_marker u_sub1 (
		.sys_clk(sys_clk),
		.rst(rst),
		.clk_en(clk_en),
		.trig(dec_trig[SCLTG_DEC_SUB1]),
		.gclk(line_count_r[SCLTG_SUB_CLK_BIT]),
		.pulse_r(sub_sync1_mark)
	); // R19

	scltg_marker u_sub2 (
		.sys_clk(sys_clk),
		.rst(rst),
		.clk_en(clk_en),
		.trig(dec_trig[SCLTG_DEC_SUB2]),
		.gclk(line_count_r[SCLTG_SUB_CLK_BIT]),
		.pulse_r(sub_sync2_mark)
	); // R19

	scltg_marker u_post (
		.sys_clk(sys_clk),
		.rst(rst),
		.clk_en(clk_en),
		.trig(dec_trig[SCLTG_DEC_POST]),
		.gclk(line_count_r[SCLTG_CAL_CLK_BIT]),
		.pulse_r(post_sync_mark)
	); // R19

	// Sync steps: pickup arrives, then the next 300 kHz edge takes it
	sequence s_pickup_wait;
		pickup && !tick;
	endsequence

	property p_sync_wait;
		@(posedge sys_clk) disable iff (rst)
		s_pickup_wait |=> pend_r;
	endproperty
	a_sync_wait: assert property (p_sync_wait) else $error("once-around pulse lost"); // R2

	property p_sync_edge;
		@(posedge sys_clk) disable iff (rst)
		$rose(cnt_clear_r) |-> $past(clk300_r && !clk300_d_r);
	endproperty
	a_sync_edge: assert property (p_sync_edge) else $error("line start off the 300 kHz edge"); // R1

	property p_clear;
		@(posedge sys_clk) disable iff (rst)
		sync |=> (line_count_r == 16'h0000) && cnt_clear_r;
	endproperty
	a_clear: assert property (p_clear) else $error("counter not cleared at line start"); // R4

	property p_gates;
		@(posedge sys_clk) disable iff (rst)
		sync |=> level_clamp_space_r && level_clamp_ground_r && mirror_phase_r;
	endproperty
	a_gates: assert property (p_gates) else $error("pickup pulses missing at line start"); // R3

	property p_phase_width;
		@(posedge sys_clk) disable iff (rst)
		(mirror_phase_r && tick && !sync) |=> !mirror_phase_r;
	endproperty
	a_phase_width: assert property (p_phase_width) else $error("phase reference too long"); // R5

	property p_count;
		@(posedge sys_clk) disable iff (rst)
		(tick && !sync) |=> line_count_r == $past(line_count_r) + 16'h0001;
	endproperty
	a_count: assert property (p_count) else $error("primary counter skipped"); // R6

	property p_step_end;
		@(posedge sys_clk) disable iff (rst)
		(step_gate_r && cal_tick && step_level_r == 3'h7 && !dec_trig[SCLTG_DEC_STEP])
			|=> !step_gate_r && step_level_r == 3'h0;
	endproperty
	a_step_end: assert property (p_step_end) else $error("step gate held past full count"); // R18

	property p_step_start;
		@(posedge sys_clk) disable iff (rst)
		dec_trig[SCLTG_DEC_STEP] |=> step_gate_r ##1 (!$past(clk_en) || blank_r);
	endproperty
	a_step_start: assert property (p_step_start) else $error("step sequence not started"); // R17

endmodule // scltg_top
